// ---- pkg/pqm_pkg.sv ----
package pqm_pkg;

	localparam int PN_W       = 3;
	localparam int NPKT       = 8;
	localparam int PG_AW      = 6;
	localparam int PG_WORDS   = 64;
	localparam int MEM_AW     = PN_W + PG_AW;
	localparam logic [15:0] PAGE_BYTES = 16'h0100;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_MMU   = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_ARES  = 8'h0C;
	localparam logic [7:0] OFS_PNR   = 8'h10;
	localparam logic [7:0] OFS_PTR   = 8'h14;
	localparam logic [7:0] OFS_DATA  = 8'h18;
	localparam logic [7:0] OFS_FPORT = 8'h1C;
	localparam logic [7:0] OFS_CSR   = 8'h20;

	// Field positions in transmit_control_reg.
	localparam int TRANSMIT_ENABLE_BIT  = 0;
	localparam int DIAG_LOOPBACK_DUPLEX = 1;
	localparam int SWITCHED_FULL_DUPLEX = 2;
	localparam int RECEIVE_ENABLE_BIT   = 3;
	localparam int AUTO_RELEASE_BIT     = 4;
	localparam int WAKE_ENABLE_BIT      = 5;
	localparam int CTRL_W               = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

	// Field positions in the status register.
	localparam int ST_ALLOC_DONE = 0;
	localparam int ST_TX_INT     = 1;
	localparam int ST_TX_DRAINED = 2;
	localparam int ST_RCV_INT    = 3;
	localparam int ST_ALLOC_PEND = 4;
	localparam int ST_TX_FAIL    = 5;

	// Interframe gap, a least time, rounded up.
	localparam int CLK_MHZ = 100;
	localparam int IFG_NS  = 9600;
	localparam int IFG_CYC = (IFG_NS * CLK_MHZ + 999) / 1000;
	localparam logic [9:0] IFG_LAST = 10'(IFG_CYC - 1);

	typedef enum logic [2:0] {
		CMD_NOP   = 3'h0,
		CMD_ALLOC = 3'h1,
		CMD_ENQ   = 3'h2,
		CMD_REL   = 3'h3,
		CMD_RXREL = 3'h4,
		CMD_TXACK = 3'h5
	} pqm_cmd_e;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_BUSY = 2'h1,
		TX_GAP  = 2'h2
	} pqm_txst_e;

	typedef struct packed {
		logic        valid;
		logic        ok;
		logic [15:0] status;
	} pqm_txres_s;

	typedef struct packed {
		logic        sof;
		logic        wr;
		logic        eof;
		logic        crc_ok;
		logic        wake;
		logic [31:0] data;
		logic [15:0] stat;
		logic [15:0] bcnt;
	} pqm_rxin_s;

endpackage : pqm_pkg

// ---- rtl/pqm_queue_manager.sv ----
`timescale 1ns/1ns

module pqm_pnfifo #(
	parameter int W  = 3,
	parameter int AW = 3
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         push,
	input  wire logic [W-1:0] din,
	input  wire logic         pop,
	output logic      [W-1:0] head,
	output logic              empty,
	output logic              full
);
	logic [W-1:0]  mem_q [2**AW];
	logic [AW-1:0] rp_q;
	logic [AW-1:0] wp_q;
	logic [AW:0]   cnt_q;
	logic          do_push;
	logic          do_pop;

	assign empty   = (cnt_q == '0);
	assign full    = cnt_q[AW];
	assign head    = mem_q[rp_q];
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_q[wp_q] <= din;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rp_q  <= '0;
			wp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (do_pop) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : pqm_pnfifo

module pqm_queue_manager import pqm_pkg::*; (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire logic               crs_pin,
	input  wire pqm_txres_s         tx_res,
	input  wire logic [PG_AW-1:0]   tx_rd_addr,
	output logic [31:0]             tx_rd_data,
	output logic                    tx_go,
	output logic [PN_W-1:0]         tx_pnum,
	input  wire pqm_rxin_s          rx_in,
	output logic                    loopback,
	output logic                    col_det_en,
	output logic                    wake_irq,
	output logic                    lowpower_ok
);
	logic [31:0]       mem_q [NPKT*PG_WORDS];
	logic [CTRL_W-1:0] transmit_control_reg_q;
	logic              config_status_reg_q;
	logic              ap_q, ap_wr_q, rdy_q;
	logic [7:0]        ap_a_q;
	logic [31:0]       rdata_q, tx_rd_q;
	logic [PN_W-1:0]   pnr_q, ares_q, fail_pn_q, tx_pn_q, rx_pn_q;
	logic [PG_AW-1:0]  ptr_q;
	logic              alloc_done_flag_q, alloc_pend_q, fail_q;
	logic              tx_queue_drained_flag_q;
	logic [NPKT-1:0]   free_q;
	logic              crs_m_q, crs_s_q;
	pqm_txst_e         txst_q;
	logic [9:0]        gap_q;
	logic              go_q, loop_q, coln_q, wirq_q, lpok_q;
	logic              txst_pend_q;
	logic [15:0]       txst_q_w;
	logic              rx_act_q, rx_crc_q;
	logic [PG_AW:0]    rx_wp_q;
	logic [1:0]        rx_fin_q;
	logic [15:0]       rx_stat_q, rx_bcnt_q;

	wire sw_dup   = transmit_control_reg_q[SWITCHED_FULL_DUPLEX];
	wire auto_rel = transmit_control_reg_q[AUTO_RELEASE_BIT];
	wire wake_en  = transmit_control_reg_q[WAKE_ENABLE_BIT];
	wire take     = hsel & hready & htrans[1];
	wire rx_wr_ok = rx_act_q & rx_in.wr & ~rx_wp_q[PG_AW];
	wire mport_busy = (rx_fin_q != 2'b00) | rx_wr_ok | txst_pend_q;
	wire done     = ap_q & ~(ap_wr_q & (ap_a_q == OFS_DATA) & mport_busy);
	wire wr_stb   = done & ap_wr_q;
	wire rd_stb   = done & ~ap_wr_q;
	wire pqm_cmd_e cmd = pqm_cmd_e'(hwdata[2:0]);
	wire cmd_stb  = wr_stb & (ap_a_q == OFS_MMU);

	// First free page; receive claims it before a waiting transmit request.
	logic            any_free;
	logic [PN_W-1:0] first_free;
	always_comb begin
		any_free   = 1'b0;
		first_free = '0;
		for (int i = NPKT - 1; i >= 0; i--) begin
			if (free_q[i]) begin
				any_free   = 1'b1;
				first_free = PN_W'(i);
			end
		end
	end

	// FIFOs of packet numbers.
	logic [PN_W-1:0] txf_head, cmp_head, rxf_head;
	logic            txf_empty, cmp_empty, rxf_empty, rxf_full;
	wire tx_fin   = (txst_q == TX_BUSY) & tx_res.valid;
	wire rx_take  = rx_in.sof & ~rx_act_q & (rx_fin_q == 2'b00) &
		transmit_control_reg_q[RECEIVE_ENABLE_BIT] & any_free & ~rxf_full;
	wire rx_ovr   = rx_act_q & rx_in.wr & rx_wp_q[PG_AW];
	wire rx_push  = rx_fin_q[1] & rx_crc_q;
	wire enq      = cmd_stb & (cmd == CMD_ENQ);
	wire rxrel    = cmd_stb & (cmd == CMD_RXREL) & ~rxf_empty;
	wire txack    = cmd_stb & (cmd == CMD_TXACK);
	// A fresh allocate command replaces the waiting one; a grant in that
	// same cycle would claim a page that no result register remembers.
	wire tx_grant = alloc_pend_q & any_free & ~rx_take &
		~(cmd_stb & (cmd == CMD_ALLOC));

	pqm_pnfifo #(.W(PN_W), .AW(PN_W)) u_txf (
		.clk(hclk), .rst_n(hresetn),
		.push(enq), .din(pnr_q), .pop(tx_fin),
		.head(txf_head), .empty(txf_empty), .full());
	pqm_pnfifo #(.W(PN_W), .AW(PN_W)) u_cmp (
		.clk(hclk), .rst_n(hresetn),
		.push(tx_fin & tx_res.ok & ~auto_rel),
		.din(txf_head), .pop(txack & ~fail_q),
		.head(cmp_head), .empty(cmp_empty), .full());
	pqm_pnfifo #(.W(PN_W), .AW(PN_W)) u_rxf (
		.clk(hclk), .rst_n(hresetn),
		.push(rx_push), .din(rx_pn_q), .pop(rxrel),
		.head(rxf_head), .empty(rxf_empty), .full(rxf_full));

	// AHB-Lite slave: every transfer takes one wait state; a data write waits longer while the memory port is busy.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_q    <= 1'b0;
			ap_wr_q <= 1'b0;
			ap_a_q  <= 8'h00;
			rdy_q   <= 1'b1;
		end else if (take) begin
			ap_q    <= 1'b1;
			ap_wr_q <= hwrite;
			ap_a_q  <= haddr[7:0];
			rdy_q   <= 1'b0;
		end else if (done) begin
			ap_q  <= 1'b0;
			rdy_q <= 1'b1;
		end
	end

	logic [31:0] rdmux;
	always_comb begin
		rdmux = 32'h0000_0000;
		unique case (ap_a_q)
			OFS_CTRL:  rdmux[CTRL_W-1:0] = transmit_control_reg_q;
			OFS_STAT:  rdmux[5:0] = {fail_q, alloc_pend_q, ~rxf_empty,
				tx_queue_drained_flag_q, fail_q | ~cmp_empty,
				alloc_done_flag_q};
			OFS_ARES:  rdmux[PN_W-1:0] = ares_q;
			OFS_PNR:   rdmux[PN_W-1:0] = pnr_q;
			OFS_PTR:   rdmux[PG_AW-1:0] = ptr_q;
			OFS_DATA:  rdmux = mem_q[{pnr_q, ptr_q}];
			OFS_FPORT: rdmux = {16'h0000, ~rxf_empty ? 1'b0 : 1'b1,
				4'h0, rxf_head, fail_q | ~cmp_empty ? 1'b0 : 1'b1,
				4'h0, fail_q ? fail_pn_q : cmp_head};
			OFS_CSR:   rdmux[0] = config_status_reg_q;
			default:   rdmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_stb) begin
			rdata_q <= rdmux;
		end
	end

	// Host writes control; a transmit failure wins over a host write to the enable bit.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			transmit_control_reg_q <= CTRL_RST;
		end else begin
			if (wr_stb && ap_a_q == OFS_CTRL) begin
				transmit_control_reg_q <= hwdata[CTRL_W-1:0];
			end
			if (tx_fin && !tx_res.ok) begin
				transmit_control_reg_q[TRANSMIT_ENABLE_BIT] <= 1'b0;
			end
		end
	end

	// Packet select and data window pointer; the pointer auto-increments.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pnr_q <= '0;
			ptr_q <= '0;
		end else begin
			if (wr_stb && ap_a_q == OFS_PNR) begin
				pnr_q <= hwdata[PN_W-1:0];
			end
			if (wr_stb && ap_a_q == OFS_PTR) begin
				ptr_q <= hwdata[PG_AW-1:0];
			end else if (done && ap_a_q == OFS_DATA) begin
				ptr_q <= ptr_q + 1'b1;
			end
		end
	end

	// One memory write port; receive writes never wait, the transmit status write and the host do.
	logic              mwe;
	logic [MEM_AW-1:0] maddr;
	logic [31:0]       mwd;
	always_comb begin
		mwe   = 1'b0;
		maddr = '0;
		mwd   = 32'h0000_0000;
		if (rx_fin_q[1]) begin
			mwe   = 1'b1;
			maddr = {rx_pn_q, 6'h01};
			mwd   = {16'h0000, rx_bcnt_q};
		end else if (rx_fin_q[0]) begin
			mwe   = 1'b1;
			maddr = {rx_pn_q, 6'h00};
			mwd   = {16'h0000, rx_stat_q};
		end else if (rx_wr_ok) begin
			mwe   = 1'b1;
			maddr = {rx_pn_q, rx_wp_q[PG_AW-1:0]};
			mwd   = rx_in.data;
		end else if (txst_pend_q) begin
			mwe   = 1'b1;
			maddr = {tx_pn_q, 6'h00};
			mwd   = {16'h0000, txst_q_w};
		end else if (wr_stb && ap_a_q == OFS_DATA) begin
			mwe   = 1'b1;
			maddr = {pnr_q, ptr_q};
			mwd   = hwdata;
		end
	end

	always_ff @(posedge hclk) begin
		if (mwe) begin
			mem_q[maddr] <= mwd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_rd_q <= 32'h0000_0000;
		end else begin
			tx_rd_q <= mem_q[{tx_pn_q, tx_rd_addr}];
		end
	end

	// Page map: several releases and one claim may land in one cycle.
	logic [NPKT-1:0] rel_m, clm_m;
	always_comb begin
		rel_m = '0;
		clm_m = '0;
		if (cmd_stb && cmd == CMD_REL) rel_m[pnr_q] = 1'b1;
		if (rxrel) rel_m[rxf_head] = 1'b1;
		if (tx_fin && tx_res.ok && auto_rel) rel_m[txf_head] = 1'b1;
		if (rx_ovr) rel_m[rx_pn_q] = 1'b1;
		if (rx_fin_q[1] && !rx_crc_q) rel_m[rx_pn_q] = 1'b1;
		if (rx_take) clm_m[first_free] = 1'b1;
		if (tx_grant) clm_m[first_free] = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			free_q <= {NPKT{1'b1}};
		end else begin
			free_q <= (free_q | rel_m) & ~clm_m;
		end
	end

	// Transmit allocation; an oversize request is never granted.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alloc_pend_q      <= 1'b0;
			alloc_done_flag_q <= 1'b0;
			ares_q            <= '0;
		end else if (cmd_stb && cmd == CMD_ALLOC) begin
			alloc_done_flag_q <= 1'b0;
			alloc_pend_q      <= (hwdata[31:16] <= PAGE_BYTES);
		end else if (tx_grant) begin
			alloc_pend_q      <= 1'b0;
			alloc_done_flag_q <= 1'b1;
			ares_q            <= first_free;
		end
	end

	a_alloc_grant: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_grant |=> alloc_done_flag_q && !free_q[ares_q])
		else $error("allocation grant not reported");
	a_alloc_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		alloc_pend_q && !any_free |=> !alloc_done_flag_q)
		else $error("allocation done without free memory");

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			crs_m_q <= 1'b0;
			crs_s_q <= 1'b0;
		end else begin
			crs_m_q <= crs_pin;
			crs_s_q <= crs_m_q;
		end
	end

	// Transmit sequencer.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txst_q  <= TX_IDLE;
			go_q    <= 1'b0;
			tx_pn_q <= '0;
			gap_q   <= 10'h000;
		end else begin
			go_q <= 1'b0;
			unique case (txst_q)
				TX_IDLE: begin
					if (transmit_control_reg_q[TRANSMIT_ENABLE_BIT] &&
						!txf_empty && (sw_dup || !crs_s_q)) begin
						go_q    <= 1'b1;
						tx_pn_q <= txf_head;
						txst_q  <= TX_BUSY;
					end
				end
				TX_BUSY: begin
					if (tx_res.valid) begin
						gap_q  <= IFG_LAST;
						txst_q <= TX_GAP;
					end
				end
				TX_GAP: begin
					if (gap_q == 10'h000) begin
						txst_q <= TX_IDLE;
					end else begin
						gap_q <= gap_q - 1'b1;
					end
				end
				default: txst_q <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txst_pend_q <= 1'b0;
			txst_q_w    <= 16'h0000;
			fail_q      <= 1'b0;
			fail_pn_q   <= '0;
		end else begin
			if (tx_fin) begin
				txst_pend_q <= 1'b1;
				txst_q_w    <= tx_res.status;
			end else if (!(rx_fin_q != 2'b00 || rx_wr_ok)) begin
				txst_pend_q <= 1'b0;
			end
			if (tx_fin && !tx_res.ok) begin
				fail_q    <= 1'b1;
				fail_pn_q <= txf_head;
			end else if (txack) begin
				fail_q <= 1'b0;
			end
		end
	end

	// Drained flag latches an empty TX FIFO; a new empty beats the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_queue_drained_flag_q <= 1'b0;
		end else if (txf_empty) begin
			tx_queue_drained_flag_q <= 1'b1;
		end else if (wr_stb && ap_a_q == OFS_STAT && hwdata[ST_TX_DRAINED]) begin
			tx_queue_drained_flag_q <= 1'b0;
		end
	end

	sequence s_tx_fail;
		txst_q == TX_BUSY && tx_res.valid && !tx_res.ok;
	endsequence
	sequence s_tx_stopped;
		!transmit_control_reg_q[TRANSMIT_ENABLE_BIT] && fail_q &&
			fail_pn_q == $past(txf_head);
	endsequence
	a_fail_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		s_tx_fail |=> s_tx_stopped)
		else $error("transmit failure did not stop the queue");
	a_go_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
		go_q |-> $past(transmit_control_reg_q[TRANSMIT_ENABLE_BIT]) &&
			($past(sw_dup) || !$past(crs_s_q)))
		else $error("transmit started while not permitted");
	a_gap_kept: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_fin |=> !go_q [*8])
		else $error("interframe gap not kept");
	a_auto_free: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_fin && tx_res.ok && auto_rel |=> free_q[$past(txf_head)])
		else $error("auto release did not free the page");

	// Receive path.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_act_q  <= 1'b0;
			rx_pn_q   <= '0;
			rx_wp_q   <= '0;
			rx_fin_q  <= 2'b00;
			rx_crc_q  <= 1'b0;
			rx_stat_q <= 16'h0000;
			rx_bcnt_q <= 16'h0000;
		end else begin
			rx_fin_q <= {rx_fin_q[0], 1'b0};
			if (rx_take) begin
				rx_act_q <= 1'b1;
				rx_pn_q  <= first_free;
				rx_wp_q  <= 7'h02;
			end else if (rx_ovr) begin
				rx_act_q <= 1'b0;
			end else if (rx_wr_ok) begin
				rx_wp_q <= rx_wp_q + 1'b1;
			end else if (rx_act_q && rx_in.eof) begin
				rx_act_q  <= 1'b0;
				rx_fin_q  <= 2'b01;
				rx_crc_q  <= rx_in.crc_ok;
				rx_stat_q <= rx_in.stat;
				rx_bcnt_q <= rx_in.bcnt;
			end
		end
	end

	a_rx_enable: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(rx_act_q) |-> $past(transmit_control_reg_q[RECEIVE_ENABLE_BIT]))
		else $error("reception started while disabled");
	a_crc_drop: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_fin_q[1] && !rx_crc_q |=> free_q[$past(rx_pn_q)] &&
			$stable(rxf_empty))
		else $error("bad frame kept or queued");

	// Mode outputs and wake handling.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loop_q <= 1'b0;
			coln_q <= 1'b1;
			lpok_q <= 1'b1;
		end else begin
			loop_q <= transmit_control_reg_q[DIAG_LOOPBACK_DUPLEX] & ~sw_dup;
			coln_q <= ~sw_dup;
			lpok_q <= ~wake_en;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_status_reg_q <= 1'b0;
			wirq_q              <= 1'b0;
		end else begin
			if (wake_en && rx_in.wake) begin
				config_status_reg_q <= 1'b1;
			end else if (wr_stb && ap_a_q == OFS_CSR && hwdata[0]) begin
				config_status_reg_q <= 1'b0;
			end
			wirq_q <= wake_en & config_status_reg_q;
		end
	end

	a_no_loop_sw: assert property (@(posedge hclk) disable iff (!hresetn)
		sw_dup |=> !loop_q && !coln_q)
		else $error("switched duplex still loops or detects collisions");
	a_wake_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		wake_en && rx_in.wake |=> config_status_reg_q ##1 wirq_q || !wake_en)
		else $error("wake frame not reported");

	assign hreadyout   = rdy_q;
	assign hresp       = 1'b0;
	assign hrdata      = rdata_q;
	assign tx_rd_data  = tx_rd_q;
	assign tx_go       = go_q;
	assign tx_pnum     = tx_pn_q;
	assign loopback    = loop_q;
	assign col_det_en  = coln_q;
	assign wake_irq    = wirq_q;
	assign lowpower_ok = lpok_q;
endmodule : pqm_queue_manager

// ---- tb/pqm_mac_model.sv ----
`timescale 1ns/1ns

// Stands in for the CSMA/CD side: answers each start pulse after a fixed
// time, as a success or, when told to, as a failure.
module pqm_mac_model import pqm_pkg::*; #(
	parameter int DLY = 20
) (
	input  wire logic            hclk,
	input  wire logic            tx_go,
	input  wire logic [PN_W-1:0] tx_pnum,
	input  wire logic            fail,
	output pqm_txres_s           tx_res,
	output int                   n_go,
	output logic [PN_W-1:0]      last_pn
);
	initial begin
		tx_res = '{1'b0, 1'b0, 16'hFFFF};
		n_go = 0;
		last_pn = '0;
	end

	// Outside the answer pulse the status lines carry junk, not the result.
	always @(posedge hclk) begin
		if (tx_go === 1'b1) begin
			n_go <= n_go + 1;
			last_pn <= tx_pnum;
			repeat (DLY) @(posedge hclk);
			tx_res <= '{1'b1, !fail, {15'h0000, !fail}};
			@(posedge hclk);
			tx_res <= '{1'b0, fail, 16'hFFFE};
		end
	end
endmodule : pqm_mac_model

// ---- tb/test_packet_queue_manager.sv ----
`timescale 1ns/1ns

module test_packet_queue_manager import pqm_pkg::*;;
	logic            hclk;
	logic            hresetn;
	logic            hsel;
	logic [31:0]     haddr;
	logic [1:0]      htrans;
	logic            hwrite;
	logic [2:0]      hsize;
	logic [31:0]     hwdata;
	logic            hreadyout;
	logic            hresp;
	logic [31:0]     hrdata;
	logic            crs_pin;
	pqm_txres_s      tx_res;
	logic            tx_go;
	logic [PN_W-1:0] tx_pnum;
	pqm_rxin_s       rx_in;
	logic            loopback;
	logic            col_det_en;
	logic            wake_irq;
	logic            lowpower_ok;
	logic [5:0]      tx_addr;
	logic [31:0]     tx_rd_data;
	logic            mac_fail;
	int              n_go;
	logic [PN_W-1:0] last_pn;
	int              n_errors;
	int              checks_done;

	pqm_queue_manager DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .crs_pin(crs_pin), .tx_res(tx_res),
		.tx_rd_addr(tx_addr), .tx_rd_data(tx_rd_data),
		.tx_go(tx_go),
		.tx_pnum(tx_pnum), .rx_in(rx_in), .loopback(loopback),
		.col_det_en(col_det_en), .wake_irq(wake_irq),
		.lowpower_ok(lowpower_ok)
	);

	pqm_mac_model mac (
		.hclk(hclk), .tx_go(tx_go), .tx_pnum(tx_pnum), .fail(mac_fail),
		.tx_res(tx_res), .n_go(n_go), .last_pn(last_pn)
	);

	always #5 hclk = ~hclk;

	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// The bus wait has no bound of its own; the watchdog ends a hang.
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h00000000, r);
		chk($sformatf("reg %h", a), e, r & m);
	endtask : rchk

	task automatic poll(input int b, input logic v);
		logic [31:0] r;
		int i;
		i = 0;
		do begin
			ahb(1'b0, OFS_STAT, 32'h00000000, r);
			i++;
		end while (r[b] !== v && i < 600);
		chk("status bit", 32'(v), 32'(r[b]));
	endtask : poll

	task automatic rxp(input pqm_rxin_s v);
		@(posedge hclk);
		rx_in <= v;
		@(posedge hclk);
		rx_in <= '0;
	endtask : rxp

	task automatic t_reset;
		chk("col_det_en", 32'h1, 32'(col_det_en));
		chk("lowpower_ok", 32'h1, 32'(lowpower_ok));
		chk("hresp", 32'h0, 32'(hresp));
		rchk(OFS_CTRL, 32'hFFFFFFFF, 32'h00000000);
		rchk(OFS_FPORT, 32'h00008080, 32'h00008080);
		rchk(8'h40, 32'hFFFFFFFF, 32'h00000000);
	endtask : t_reset

	task automatic t_modes;
		wr(OFS_CTRL, 32'h00000002);
		repeat (2) @(posedge hclk);
		chk("loopback", 32'h1, 32'(loopback));
		chk("col_det_en", 32'h1, 32'(col_det_en));
		wr(OFS_CTRL, 32'h00000006);
		repeat (2) @(posedge hclk);
		chk("loopback", 32'h0, 32'(loopback));
		chk("col_det_en", 32'h0, 32'(col_det_en));
		wr(OFS_CTRL, 32'h00000000);
	endtask : t_modes

	task automatic t_alloc(output logic [31:0] pn);
		wr(OFS_MMU, 32'h00400001);
		poll(ST_ALLOC_DONE, 1'b1);
		ahb(1'b0, OFS_ARES, 32'h00000000, pn);
		pn = pn & 32'h00000007;
	endtask : t_alloc

	// Carrier is held busy first: only the switched mode may start then.
	// Transmit is switched off first, so an enqueue cannot start early.
	task automatic t_tx(input logic fail, input logic ar, input logic sw);
		logic [31:0] pn;
		int g;
		wr(OFS_CTRL, 32'h00000000);
		t_alloc(pn);
		wr(OFS_PNR, pn);
		wr(OFS_PTR, 32'h00000000);
		wr(OFS_DATA, 32'hA5A50001);
		wr(OFS_DATA, 32'h5A5A0002);
		wr(OFS_PTR, 32'h00000001);
		rchk(OFS_DATA, 32'hFFFFFFFF, 32'h5A5A0002);
		wr(OFS_MMU, 32'h00000002);
		wr(OFS_STAT, 32'h00000004);
		g = n_go;
		mac_fail <= fail;
		crs_pin <= 1'b1;
		wr(OFS_CTRL, {27'h0000000, ar, 1'b0, sw, 2'h1});
		repeat (1000) @(posedge hclk);
		chk("started", 32'(sw), 32'(n_go > g));
		crs_pin <= 1'b0;
		poll(ar ? ST_TX_DRAINED : ST_TX_INT, 1'b1);
		if (ar) begin
			rchk(OFS_FPORT, 32'h00000080, 32'h00000080);
			rchk(OFS_STAT, 32'h00000002, 32'h00000000);
			wr(OFS_STAT, 32'h00000004);
		end else begin
			chk("tx pnum", pn, 32'(last_pn));
			chk("tx_rd_data", 32'h5A5A0002, tx_rd_data);
			rchk(OFS_FPORT, 32'h00000007, pn);
			rchk(OFS_STAT, 32'h00000020, 32'(fail) << 5);
			rchk(OFS_CTRL, 32'h00000001, 32'(!fail));
			wr(OFS_PTR, 32'h00000000);
			rchk(OFS_DATA, 32'h0000FFFF, 32'(!fail));
			wr(OFS_MMU, 32'h00000003);
			wr(OFS_MMU, 32'h00000005);
			rchk(OFS_STAT, fail ? 32'h20 : 32'h22, 32'h0);
		end
	endtask : t_tx

	task automatic t_rx(input logic en, input logic crc, input int nw);
		logic [31:0] r;
		logic ok;
		ok = en & crc & (nw <= PG_WORDS - 2);
		wr(OFS_CTRL, {28'h0000000, en, 3'h0});
		rxp('{sof:1'b1, default:'0});
		for (int i = 0; i < nw; i++) begin
			rxp('{wr:1'b1, data:32'hC0DE0000 + i, default:'0});
		end
		rxp('{eof:1'b1, crc_ok:crc, stat:16'h1234, bcnt:16'h000C,
			default:'0});
		repeat (4) @(posedge hclk);
		rchk(OFS_STAT, 32'h00000008, 32'(ok) << 3);
		if (ok) begin
			ahb(1'b0, OFS_FPORT, 32'h00000000, r);
			wr(OFS_PNR, {29'h00000000, r[10:8]});
			wr(OFS_PTR, 32'h00000000);
			rchk(OFS_DATA, 32'h0000FFFF, 32'h00001234);
			rchk(OFS_DATA, 32'h0000FFFF, 32'h0000000C);
			rchk(OFS_DATA, 32'hFFFFFFFF, 32'hC0DE0000);
			wr(OFS_MMU, 32'h00000004);
			rchk(OFS_STAT, 32'h00000008, 32'h00000000);
		end
	endtask : t_rx

	task automatic t_wake(input logic en);
		wr(OFS_CTRL, 32'(en) << 5);
		rxp('{wake:1'b1, default:'0});
		repeat (3) @(posedge hclk);
		chk("lowpower_ok", 32'(!en), 32'(lowpower_ok));
		chk("wake_irq", 32'(en), 32'(wake_irq));
		rchk(OFS_CSR, 32'h00000001, 32'(en));
		wr(OFS_CSR, 32'h00000001);
	endtask : t_wake

	// Every page is claimed first, so the last request has to wait.
	task automatic t_full;
		logic [31:0] pn;
		for (int i = 0; i < NPKT; i++) begin
			t_alloc(pn);
		end
		wr(OFS_MMU, 32'h00400001);
		repeat (50) @(posedge hclk);
		rchk(OFS_STAT, 32'h00000011, 32'h00000010);
		wr(OFS_PNR, pn);
		wr(OFS_MMU, 32'h00000003);
		poll(ST_ALLOC_DONE, 1'b1);
		wr(OFS_MMU, 32'h02000001);
		repeat (50) @(posedge hclk);
		rchk(OFS_STAT, 32'h00000011, 32'h00000000);
	endtask : t_full

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		crs_pin = 1'b0;
		rx_in = '0;
		mac_fail = 1'b0;
		tx_addr = 6'h01;
		n_errors = 0;
		checks_done = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_modes();
		t_tx(1'b0, 1'b0, 1'b0);
		t_tx(1'b1, 1'b0, 1'b0);
		t_tx(1'b0, 1'b1, 1'b1);
		t_rx(1'b0, 1'b1, 2);
		t_rx(1'b1, 1'b0, 2);
		t_rx(1'b1, 1'b1, 70);
		t_rx(1'b1, 1'b1, 2);
		t_wake(1'b1);
		t_wake(1'b0);
		t_full();
		final_report();
	end

	initial begin
		#900000;
		n_errors++;
		final_report();
	end
endmodule : test_packet_queue_manager
